// file: shared/sid_pkg.sv
package sid_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Widths
    localparam int SID_DATA_W = 32;
    localparam int SID_DIVISOR_W = 16;
    localparam int SID_ADDR_W = 8;
    localparam int SID_STRB_W = 4;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [SID_ADDR_W-1:0] SID_OFF_DIVIDEND = 8'h00;
    localparam logic [SID_ADDR_W-1:0] SID_OFF_DIVISOR = 8'h04;
    localparam logic [SID_ADDR_W-1:0] SID_OFF_QUOTIENT = 8'h08;
    localparam logic [SID_ADDR_W-1:0] SID_OFF_REMAINDER = 8'h0c;
    localparam logic [SID_ADDR_W-1:0] SID_OFF_STATUS = 8'h10;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values and fields
    localparam logic [31:0] SID_RST_DIVIDEND = 32'h0000_0000;
    localparam logic [31:0] SID_RST_DIVISOR = 32'h0000_ffff;
    localparam logic [31:0] SID_RST_QUOTIENT = 32'h0000_0000;
    localparam logic [31:0] SID_RST_REMAINDER = 32'h0000_0000;
    localparam logic [31:0] SID_RST_STATUS = 32'h0000_0001;
    localparam int SID_ZERO_FLAG_BIT = 1;
    localparam logic [31:0] SID_ZDIV_QUOTIENT = 32'hffff_ffff;
    localparam logic [31:0] SID_ZDIV_REMAINDER = 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int SID_DIV_CYCLES = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Bus carriers
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [SID_ADDR_W-1:0] paddr;
        logic [SID_DATA_W-1:0] pwdata;
        logic [SID_STRB_W-1:0] pstrb;
    } sid_apb_req_t;

    typedef struct packed {
        logic pready;
        logic [SID_DATA_W-1:0] prdata;
        logic pslverr;
    } sid_apb_rsp_t;

    // Merge write data into a word under byte strobes
    function automatic logic [31:0] sid_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                              input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction : sid_merge

endpackage : sid_pkg

// file: src/sid_cycle_timer.sv
`timescale 1ns/1ps
`default_nettype none
module sid_cycle_timer #(
    parameter int CYCLES = sid_pkg::SID_DIV_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Control
    input wire logic start_in,
    // Status
    output logic busy_out,
    output logic done_out
);
    import sid_pkg::*;

    localparam int CNT_W = 4;

    generate
        if (CYCLES < 1 || CYCLES > 15) begin : g_bad_cycles
            $error("sid_cycle_timer: CYCLES must be 1 to 15");
        end
    endgenerate

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } sid_tmr_state_t;

    sid_tmr_state_t s_q;
    sid_tmr_state_t s_d;

    always_comb begin
        s_d = s_q;
        if (start_in) begin
            s_d.cnt = CNT_W'(CYCLES);
        end else if (s_q.cnt != '0) begin
            s_d.cnt = s_q.cnt - 4'h1;
        end
    end

    // A restart on the final cycle wins, so stale operands never land
    assign done_out = (s_q.cnt == 4'h1) && !start_in;
    assign busy_out = (s_q.cnt != '0);

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : sid_cycle_timer
`default_nettype wire

// file: src/sid_div_core.sv
`timescale 1ns/1ps
`default_nettype none
module sid_div_core (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Operands and control
    input wire logic start_in,
    input wire logic done_in,
    input wire logic [31:0] dividend_in,
    input wire logic [15:0] divisor_in,
    // Software writes to the result registers
    input wire logic quo_wr_in,
    input wire logic rem_wr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic [3:0] wr_strb_in,
    // Results
    output logic [31:0] quo_out,
    output logic [31:0] rem_out
);
    import sid_pkg::*;

    typedef struct packed {
        logic [31:0] op_a;
        logic [15:0] op_b;
        logic [31:0] quo;
        logic [31:0] rem;
    } sid_core_state_t;

    sid_core_state_t s_q;
    sid_core_state_t s_d;
    logic signed [32:0] a_x;
    logic signed [32:0] b_x;
    logic signed [32:0] q_x;
    logic signed [32:0] r_x;

    always_comb begin
        // 33 bits keep the most negative dividend divided by -1 defined
        a_x = signed'({s_q.op_a[31], s_q.op_a});
        b_x = signed'({{17{s_q.op_b[15]}}, s_q.op_b});
        q_x = '0;
        r_x = '0;
        if (s_q.op_b != 16'h0000) begin
            q_x = a_x / b_x;
            r_x = a_x % b_x;
        end
    end

    always_comb begin
        s_d = s_q;
        if (start_in) begin
            s_d.op_a = dividend_in;
            s_d.op_b = divisor_in;
        end
        if (quo_wr_in) begin
            s_d.quo = sid_merge(s_q.quo, wr_data_in, wr_strb_in);
        end
        if (rem_wr_in) begin
            s_d.rem = sid_merge(s_q.rem, wr_data_in, wr_strb_in);
        end
        if (done_in) begin
            if (s_q.op_b == 16'h0000) begin
                s_d.quo = SID_ZDIV_QUOTIENT;
                s_d.rem = SID_ZDIV_REMAINDER;
            end else begin
                s_d.quo = q_x[31:0];
                s_d.rem = {{16{r_x[15]}}, r_x[15:0]};
            end
        end
    end

    assign quo_out = s_q.quo;
    assign rem_out = s_q.rem;

    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q.op_a <= SID_RST_DIVIDEND;
            s_q.op_b <= SID_RST_DIVISOR[15:0];
            s_q.quo <= SID_RST_QUOTIENT;
            s_q.rem <= SID_RST_REMAINDER;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : sid_div_core
`default_nettype wire

// file: src/sid_divider.sv
`timescale 1ns/1ps
`default_nettype none
module sid_divider #(
    parameter int DIV_CYCLES = sid_pkg::SID_DIV_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire sid_pkg::sid_apb_req_t apb_req_in,
    output sid_pkg::sid_apb_rsp_t apb_rsp_out
);
    import sid_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // State
    typedef struct packed {
        logic [31:0] dividend;
        logic [15:0] divisor;
        logic zero_flag;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } sid_top_state_t;

    sid_top_state_t s_q;
    sid_top_state_t s_d;

    logic access;
    logic commit;
    logic hit_dividend;
    logic hit_divisor;
    logic hit_quo;
    logic hit_rem;
    logic hit_status;
    logic mapped;
    logic start;
    logic busy;
    logic done;
    logic quo_wr;
    logic rem_wr;
    logic [31:0] quo;
    logic [31:0] rem;
    logic [31:0] new_divisor;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////
    // Decode
    assign access = apb_req_in.psel && apb_req_in.penable;
    // The transfer ends on the edge that samples our registered pready
    assign commit = access && s_q.pready;
    assign hit_dividend = (apb_req_in.paddr[7:2] == SID_OFF_DIVIDEND[7:2]);
    assign hit_divisor = (apb_req_in.paddr[7:2] == SID_OFF_DIVISOR[7:2]);
    assign hit_quo = (apb_req_in.paddr[7:2] == SID_OFF_QUOTIENT[7:2]);
    assign hit_rem = (apb_req_in.paddr[7:2] == SID_OFF_REMAINDER[7:2]);
    assign hit_status = (apb_req_in.paddr[7:2] == SID_OFF_STATUS[7:2]);
    assign mapped = hit_dividend || hit_divisor || hit_quo || hit_rem || hit_status;

    assign start = commit && apb_req_in.pwrite && hit_divisor;
    assign quo_wr = commit && apb_req_in.pwrite && hit_quo;
    assign rem_wr = commit && apb_req_in.pwrite && hit_rem;
    assign new_divisor = sid_merge({16'h0000, s_q.divisor}, apb_req_in.pwdata, apb_req_in.pstrb);
    assign status_word = SID_RST_STATUS | (32'(s_q.zero_flag) << SID_ZERO_FLAG_BIT);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        if (access && !s_q.pready) begin
            // Result reads wait out a running division instead of returning stale data
            if (!(busy && !apb_req_in.pwrite && (hit_quo || hit_rem))) begin
                s_d.pready = 1'b1;
                s_d.pslverr = !mapped;
                s_d.prdata = 32'h0000_0000;
                if (!apb_req_in.pwrite) begin
                    case (1'b1)
                        hit_dividend: s_d.prdata = s_q.dividend;
                        hit_divisor: s_d.prdata = {16'h0000, s_q.divisor};
                        hit_quo: s_d.prdata = quo;
                        hit_rem: s_d.prdata = rem;
                        hit_status: s_d.prdata = status_word;
                        default: s_d.prdata = 32'h0000_0000;
                    endcase
                end
            end
        end
        if (commit) begin
            s_d.pslverr = 1'b0;
            s_d.prdata = 32'h0000_0000;
        end
        if (commit && apb_req_in.pwrite) begin
            if (hit_dividend) begin
                s_d.dividend = sid_merge(s_q.dividend, apb_req_in.pwdata, apb_req_in.pstrb);
            end
            if (hit_divisor) begin
                s_d.divisor = new_divisor[15:0];
                s_d.zero_flag = (new_divisor[15:0] == 16'h0000);
            end
            // Status writes fall through here and change nothing
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Datapath
    sid_cycle_timer #(
        .CYCLES(DIV_CYCLES)
    ) u_timer (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(start),
        .busy_out(busy),
        .done_out(done)
    );

    // The divisor goes straight from the write; the dividend in hand comes from the held register
    sid_div_core u_core (
        .mclk_in(mclk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(start),
        .done_in(done),
        .dividend_in(s_q.dividend),
        .divisor_in(new_divisor[15:0]),
        .quo_wr_in(quo_wr),
        .rem_wr_in(rem_wr),
        .wr_data_in(apb_req_in.pwdata),
        .wr_strb_in(apb_req_in.pstrb),
        .quo_out(quo),
        .rem_out(rem)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_q.dividend <= SID_RST_DIVIDEND;
            s_q.divisor <= SID_RST_DIVISOR[15:0];
            s_q.zero_flag <= 1'b0;
            s_q.pready <= 1'b0;
            s_q.prdata <= 32'h0000_0000;
            s_q.pslverr <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp_out.pready = s_q.pready;
    assign apb_rsp_out.prdata = s_q.prdata;
    assign apb_rsp_out.pslverr = s_q.pslverr;

endmodule : sid_divider
`default_nettype wire

// file: tb/sid_divider_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sid_divider_sva #(
    parameter int DIV_CYCLES = sid_pkg::SID_DIV_CYCLES
) (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic sys_rst_in,
    // Bus
    input wire sid_pkg::sid_apb_req_t apb_req_in,
    input wire sid_pkg::sid_apb_rsp_t apb_rsp_out
);
    import sid_pkg::*;
    logic sel, en, wr, rdy, err, res_rd, commit, zf_q;
    logic [5:0] word;
    logic [31:0] wd, rd;
    logic [3:0] busy_q;
    assign sel = apb_req_in.psel;
    assign en = apb_req_in.penable;
    assign wr = apb_req_in.pwrite;
    assign word = apb_req_in.paddr[7:2];
    assign wd = apb_req_in.pwdata;
    assign rdy = apb_rsp_out.pready;
    assign rd = apb_rsp_out.prdata;
    assign err = apb_rsp_out.pslverr;
    assign res_rd = !wr && (word == 6'h2 || word == 6'h3);
    assign commit = sel && en && rdy && wr && word == 6'h1;
    ////////////////////////////////////////////////////////////////////////////////
    // Remaining division cycles and expected zero flag (full strobes assumed)
    always_ff @(posedge mclk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            busy_q <= 4'h0;
            zf_q <= 1'b0;
        end else if (commit) begin
            busy_q <= 4'(DIV_CYCLES);
            zf_q <= (wd[15:0] == 16'h0);
        end else if (busy_q != 4'h0) begin
            busy_q <= busy_q - 4'h1;
        end
    end
    default clocking @(posedge mclk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_setup_fast;
        sel && !en && !res_rd;
    endsequence
    sequence s_res_setup;
        sel && !en && res_rd;
    endsequence
    ////////////////////////////////////////////////////////////////////////////////
    a_ready_pulse: assert property (rdy |=> !rdy)
        else $error("pready longer than one cycle");
    a_ready_in_access: assert property (rdy |-> sel && en)
        else $error("pready outside access phase");
    a_err_unmapped: assert property (rdy && word > 6'h4 |-> err && rd == 32'h0)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (rdy && word <= 6'h4 |-> !err)
        else $error("mapped access refused");
    a_idle_quiet: assert property (!rdy |-> rd == 32'h0 && !err)
        else $error("read data outside answer cycle");
    a_fast_answer: assert property (s_setup_fast ##1 (sel && en) |=> rdy)
        else $error("plain access not answered in one wait");
    a_stall_exact: assert property (commit ##1 s_res_setup |=> !rdy [*6] ##1 rdy)
        else $error("result read latency wrong");
    a_result_wait: assert property (rdy && res_rd |-> busy_q == 4'h0)
        else $error("result read answered during division");
    a_zero_flag: assert property (rdy && !wr && word == 6'h4 |-> rd == {30'h0, zf_q, 1'b1})
        else $error("status value wrong");
endmodule : sid_divider_sva
`default_nettype wire

// file: tb/sid_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module sid_cpu_model (
    // Clock
    input wire logic mclk_in,
    // APB master side
    output var sid_pkg::sid_apb_req_t req_out,
    input wire sid_pkg::sid_apb_rsp_t rsp_in
);
    import sid_pkg::*;
    initial req_out = '0;
    // Request is left standing so the next setup may follow at once
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [31:0] rd, output logic err);
        req_out <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d, pstrb: s};
        @(posedge mclk_in);
        req_out.penable <= 1'b1;
        do begin
            @(posedge mclk_in);
        end while (rsp_in.pready !== 1'b1);
        rd = rsp_in.prdata;
        err = rsp_in.pslverr;
    endtask : xfer
    task automatic idle();
        req_out <= '0;
        @(posedge mclk_in);
    endtask : idle
endmodule : sid_cpu_model
`default_nettype wire

// file: tb/signed_integer_divider_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module signed_integer_divider_tb_top;
    import sid_pkg::*;
    logic mclk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    sid_apb_req_t req;
    sid_apb_rsp_t rsp;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic err;
    // Clock runs from time zero with a 20 ns period, so reset spans two edges before any access
    always #10 mclk_in = ~mclk_in;
    sid_divider i_dut (.mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .apb_req_in(req),
                       .apb_rsp_out(rsp));
    sid_cpu_model i_cpu (.mclk_in(mclk_in), .req_out(req), .rsp_in(rsp));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    // Byte lanes matter only on writes; reads drive no strobes
    task automatic wrs(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        i_cpu.xfer(1'b1, a, d, s, rd, err);
    endtask : wrs
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wrs(a, d, 4'hf);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        i_cpu.xfer(1'b0, a, 32'h0, 4'h0, rd, err);
        chk(rd, exp, msg);
    endtask : rdc
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rdc(SID_OFF_DIVIDEND, SID_RST_DIVIDEND, "dividend reset");
        rdc(SID_OFF_DIVISOR, SID_RST_DIVISOR, "divisor reset");
        rdc(SID_OFF_QUOTIENT, SID_RST_QUOTIENT, "quotient reset");
        rdc(SID_OFF_REMAINDER, SID_RST_REMAINDER, "remainder reset");
        rdc(SID_OFF_STATUS, SID_RST_STATUS, "status reset");
        rdc(8'h14, 32'h0, "unmapped data");
        chk({31'h0, err}, 32'h1, "unmapped error");
        $display("t_reset done");
    endtask : t_reset
    task automatic t_zero();
        wr(SID_OFF_DIVIDEND, 32'd55);
        wr(SID_OFF_DIVISOR, 32'h1234_0000);
        rdc(SID_OFF_QUOTIENT, SID_ZDIV_QUOTIENT, "zero quotient");
        rdc(SID_OFF_REMAINDER, SID_ZDIV_REMAINDER, "zero remainder");
        rdc(SID_OFF_STATUS, 32'h3, "flag set");
        wr(SID_OFF_STATUS, 32'h0);
        rdc(SID_OFF_STATUS, 32'h3, "status read only");
        $display("t_zero done");
    endtask : t_zero
    task automatic t_reuse();
        // Second divisor write lands mid-division and restarts on the held dividend
        wr(SID_OFF_DIVISOR, 32'd5);
        wr(SID_OFF_DIVISOR, 32'h0000_fffc);
        rdc(SID_OFF_QUOTIENT, -32'sd13, "restart quotient");
        rdc(SID_OFF_REMAINDER, 32'd3, "restart remainder");
        rdc(SID_OFF_DIVIDEND, 32'd55, "dividend held");
        $display("t_reuse done");
    endtask : t_reuse
    task automatic t_divide();
        logic [31:0] dvd [4] = '{32'd100, -32'sd100, 32'h7fff_ffff, 32'h8000_0000};
        logic [15:0] dvs [4] = '{16'h0007, 16'h0007, 16'h8000, 16'hfff9};
        longint q;
        longint r;
        for (int i = 0; i < 4; i++) begin
            q = longint'($signed(dvd[i])) / longint'($signed(dvs[i]));
            r = longint'($signed(dvd[i])) % longint'($signed(dvs[i]));
            wr(SID_OFF_DIVIDEND, dvd[i]);
            wr(SID_OFF_DIVISOR, {16'hffff, dvs[i]});
            rdc(SID_OFF_QUOTIENT, q[31:0], "quotient");
            rdc(SID_OFF_REMAINDER, {{16{r[15]}}, r[15:0]}, "remainder");
            rdc(SID_OFF_STATUS, 32'h1, "flag clear");
            rdc(SID_OFF_DIVISOR, {16'h0, dvs[i]}, "divisor");
        end
        $display("t_divide done");
    endtask : t_divide
    task automatic t_lanes();
        // Only lane 0 lands, so the held dividend becomes 100
        wr(SID_OFF_DIVIDEND, 32'h0000_0000);
        wrs(SID_OFF_DIVIDEND, 32'hffff_ff64, 4'h1);
        rdc(SID_OFF_DIVIDEND, 32'd100, "dividend lanes");
        wr(SID_OFF_DIVISOR, 32'd7);
        // A software result write during the division is overwritten when it completes
        wr(SID_OFF_QUOTIENT, 32'h1111_1111);
        rdc(SID_OFF_QUOTIENT, 32'd14, "quotient over write");
        rdc(SID_OFF_REMAINDER, 32'd2, "remainder over write");
        $display("t_lanes done");
    endtask : t_lanes
    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge mclk_in) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end
    initial begin
        repeat (2) @(posedge mclk_in);
        sys_rst_in <= 1'b0;
        @(posedge mclk_in);
        t_reset();
        t_zero();
        t_reuse();
        t_divide();
        t_lanes();
        i_cpu.idle();
        finish_test();
    end
endmodule : signed_integer_divider_tb_top
bind sid_divider sid_divider_sva #(.DIV_CYCLES(DIV_CYCLES)) i_sva (.mclk_in(mclk_in),
    .sys_rst_in(sys_rst_in), .apb_req_in(apb_req_in), .apb_rsp_out(apb_rsp_out));
`default_nettype wire
